// [hw/pd_wake_defs.svh]
// Timing counts and fixed values of the power-down wake-up sequencer.
`ifndef PD_WAKE_DEFS_SVH
`define PD_WAKE_DEFS_SVH
`define CORE_CLK_MHZ 25
`define LATCH_PHASE_US 10
`define LATCH_PHASE_CYC ((`LATCH_PHASE_US * `CORE_CLK_MHZ + 0) / 1)
`define WAKE_DELAY_MS 5
`define WAKE_DELAY_CYC (`WAKE_DELAY_MS * 1000 * `CORE_CLK_MHZ)
`define USB_IDLE_MS 6
`define USB_IDLE_CYC (`USB_IDLE_MS * 1000 * `CORE_CLK_MHZ)
`define WAKE_VECTOR 16'h007b
`define WCFG_ENABLE_BIT 7
`define WCFG_USB_BIT 4
`define WCFG_PIN_VAL 8'h80
`define WCFG_USB_VAL 8'h90
`endif

// [hw/pd_wake_pkg.sv]
// Types of the power-down wake-up sequencer.
package pd_wake_pkg;
    typedef enum logic [2:0] {
        ST_RUN    = 3'b000,
        ST_PDOWN  = 3'b001,
        ST_LATCH  = 3'b011,
        ST_OSCWT  = 3'b010,
        ST_DELAY  = 3'b110,
        ST_HANDLR = 3'b111,
        ST_SETUP  = 3'b101
    } wake_state_e;
endpackage

// [hw/wake_pin_sync.sv]
// Three-stage synchroniser for an asynchronous input that idles high.
`timescale 1ns/1ps
module wake_pin_sync
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic i_pin,
    output logic o_level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // The first stage feeds only the second; a change counts once the
    // second and third agree.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            o_level <= 1'b1;
        end
        else
        begin
            s1_r <= i_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r)
                o_level <= s3_r;
        end
    end
endmodule

// [hw/power_down_wakeup_sequencer.sv]
// Power-down entry and wake-up sequencing for the core.
`timescale 1ns/1ps
`include "pd_wake_defs.svh"

module power_down_wakeup_sequencer
    import pd_wake_pkg::*;
#(
    parameter int WAKE_DELAY_CYC = `WAKE_DELAY_CYC,
    parameter int USB_IDLE_CYC = `USB_IDLE_CYC
)
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_power_ctrl_extension_reg,
    input wire logic i_pd_enter,
    input wire logic i_external_wake_pin,
    input wire logic i_usb_activity,
    input wire logic i_usb_rx_enable,
    input wire logic i_osc_stable,
    input wire logic i_return_from_interrupt,
    input wire logic i_usb_clock_gate,
    output logic o_powered_down,
    output logic o_rc_osc_run,
    output logic o_xtal_osc_run,
    output logic o_periph_freeze,
    output logic o_irq_mask,
    output logic o_wake_irq_req,
    output logic [15:0] o_wake_vector,
    output logic o_usb_suspend,
    output logic o_wake_src_usb
);
    localparam int LATCH_CYC = `LATCH_PHASE_CYC;

    wake_state_e state_r;
    logic [7:0] cfg_r;
    logic [31:0] cnt_r;
    logic [31:0] idle_r;
    logic pin_lvl;
    logic pin_wake;
    logic usb_wake;
    logic usb_idle_lvl;
    logic usb_act;

    wake_pin_sync u_sync
    (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_pin(i_external_wake_pin),
        .o_level(pin_lvl)
    );

    // ------------------------------------------------------------------
    // Bus activity synchroniser
    // ------------------------------------------------------------------
    // Bus activity is as asynchronous to the core clock as the wake pin.
    // The synchroniser idles high, so it is fed the inverted level and a
    // pulse still needs two agreeing samples before it counts.
    wake_pin_sync u_usb_sync
    (
        .i_core_clk(i_core_clk),
        .i_reset(i_reset),
        .i_pin(!i_usb_activity),
        .o_level(usb_idle_lvl)
    );

    assign usb_act = !usb_idle_lvl;

    // ------------------------------------------------------------------
    // Wake trigger qualification
    // ------------------------------------------------------------------
    // The configuration is captured at entry, so later writes cannot arm a
    // wake source while the core is asleep.
    assign pin_wake = cfg_r == `WCFG_PIN_VAL && !pin_lvl;
    assign usb_wake = cfg_r == `WCFG_USB_VAL && o_usb_suspend
                      && usb_act && i_usb_rx_enable;

    // ------------------------------------------------------------------
    // USB suspend detection
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            idle_r <= 32'h0;
            o_usb_suspend <= 1'b0;
        end
        else if (usb_act)
        begin
            idle_r <= 32'h0;
            o_usb_suspend <= 1'b0;
        end
        else if (idle_r > USB_IDLE_CYC)
            o_usb_suspend <= 1'b1;
        else
            idle_r <= idle_r + 32'h1;
    end

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    // Reset always lands in RUN with both oscillators on and the wake
    // vector cleared; memory contents are not part of this block.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            state_r <= ST_RUN;
            cfg_r <= 8'h00;
            cnt_r <= 32'h0;
            o_wake_src_usb <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_RUN:
                    if (i_pd_enter)
                    begin
                        cfg_r <= i_power_ctrl_extension_reg;
                        state_r <= ST_PDOWN;
                    end
                ST_PDOWN:
                    if (usb_wake)
                    begin
                        o_wake_src_usb <= 1'b1;
                        state_r <= ST_OSCWT;
                    end
                    else if (pin_wake)
                    begin
                        o_wake_src_usb <= 1'b0;
                        cnt_r <= 32'h0;
                        state_r <= ST_LATCH;
                    end
                ST_LATCH:
                    // The pin is only taken as held once low for the latch
                    // phase; an early release returns to power-down.
                    if (pin_lvl)
                        state_r <= ST_PDOWN;
                    else if (cnt_r >= LATCH_CYC - 1)
                        state_r <= ST_OSCWT;
                    else
                        cnt_r <= cnt_r + 32'h1;
                ST_OSCWT:
                    if (i_osc_stable)
                    begin
                        cnt_r <= 32'h0;
                        state_r <= ST_DELAY;
                    end
                ST_DELAY:
                    if (cnt_r >= WAKE_DELAY_CYC - 1)
                        state_r <= ST_HANDLR;
                    else
                        cnt_r <= cnt_r + 32'h1;
                ST_HANDLR:
                    // Clock setup may end inside the handler or after it.
                    if (i_return_from_interrupt)
                        state_r <= i_usb_clock_gate ? ST_RUN : ST_SETUP;
                    else if (i_usb_clock_gate)
                        state_r <= ST_SETUP;
                ST_SETUP:
                    if (i_usb_clock_gate && !o_wake_irq_req)
                        state_r <= ST_RUN;
                    else if (i_return_from_interrupt)
                        state_r <= ST_SETUP;
                default:
                    state_r <= ST_RUN;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Handler pending flag
    // ------------------------------------------------------------------
    // When the delay ends in the cycle of a stray return, the set wins, so
    // a pending wake is never dropped.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            o_wake_irq_req <= 1'b0;
        else if (state_r == ST_DELAY && cnt_r >= WAKE_DELAY_CYC - 1)
            o_wake_irq_req <= 1'b1;
        else if (i_return_from_interrupt)
            o_wake_irq_req <= 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            o_wake_vector <= 16'h0000;
        else
            o_wake_vector <= `WAKE_VECTOR;
    end

    // ------------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------------
    assign o_powered_down = state_r == ST_PDOWN || state_r == ST_LATCH;
    assign o_rc_osc_run = state_r != ST_PDOWN;
    assign o_xtal_osc_run = state_r != ST_PDOWN && state_r != ST_LATCH;
    assign o_periph_freeze = state_r != ST_RUN;
    // The wake handler itself still runs; only other sources are held off.
    assign o_irq_mask = state_r != ST_RUN && state_r != ST_PDOWN;
endmodule

// [test/wake_partner.sv]
// Model of the wake pin driver and the USB bus.
`timescale 1ns/1ps
module wake_partner
(
    input wire logic i_core_clk,
    output logic o_pin,
    output logic o_usb_act
);
    initial o_pin = 1'b1;
    initial o_usb_act = 1'b0;
    // The low phase must cover the synchroniser as well as the latch.
    task automatic pin_low(input int n);
        @(negedge i_core_clk) o_pin = 1'b0;
        repeat (n) @(negedge i_core_clk);
        o_pin = 1'b1;
    endtask
    task automatic usb_burst();
        @(negedge i_core_clk) o_usb_act = 1'b1;
        repeat (4) @(negedge i_core_clk);
        o_usb_act = 1'b0;
    endtask
endmodule

// [test/power_down_wakeup_sequencer_sva.sv]
// Port assertions of the power-down wake-up sequencer.
`timescale 1ns/1ps
module power_down_wakeup_sequencer_sva
#(
    parameter int WAKE_DELAY_CYC = 20,
    parameter int USB_IDLE_CYC = 30
)
(
    input wire logic i_core_clk,
    input wire logic i_reset,
    input wire logic [7:0] i_power_ctrl_extension_reg,
    input wire logic i_pd_enter,
    input wire logic i_usb_activity,
    input wire logic i_return_from_interrupt,
    input wire logic i_usb_clock_gate,
    input wire logic o_powered_down,
    input wire logic o_rc_osc_run,
    input wire logic o_xtal_osc_run,
    input wire logic o_periph_freeze,
    input wire logic o_irq_mask,
    input wire logic o_wake_irq_req,
    input wire logic [15:0] o_wake_vector,
    input wire logic o_usb_suspend,
    input wire logic o_wake_src_usb
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (i_reset);
    logic cfg_ok_r;
    int up_r;
    int idle_r;
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
            cfg_ok_r <= 1'b0;
        else if (i_pd_enter && !o_periph_freeze)
            cfg_ok_r <= i_power_ctrl_extension_reg inside {8'h80, 8'h90};
    end
    // Counters saturate so that a long idle spell never wraps them.
    always_ff @(posedge i_core_clk)
    begin
        if (i_reset)
        begin
            up_r <= 0;
            idle_r <= 0;
        end
        else
        begin
            up_r <= o_powered_down ? 0 : up_r + (up_r < 99999 ? 1 : 0);
            idle_r <= i_usb_activity ? 0 : idle_r + (idle_r < 99999 ? 1 : 0);
        end
    end
    sequence s_latch_start;
        $rose(o_rc_osc_run);
    endsequence
    a_reset_osc_run: assert property ($fell(i_reset) |-> o_rc_osc_run
        && o_xtal_osc_run && !o_powered_down) else $error("reset state");
    a_latch_masks: assert property (s_latch_start |-> o_irq_mask
        && (o_wake_src_usb ? !o_powered_down && o_xtal_osc_run
        : o_powered_down && !o_xtal_osc_run)) else $error("latch phase");
    a_no_wake_off: assert property (!cfg_ok_r && o_powered_down
        && !o_rc_osc_run |=> !o_rc_osc_run) else $error("wake disabled");
    a_delay_met: assert property ($rose(o_wake_irq_req)
        |-> up_r >= WAKE_DELAY_CYC) else $error("delay short");
    a_vector_fixed: assert property (o_wake_irq_req
        |-> o_wake_vector == 16'h007b) else $error("vector");
    a_mask_handler: assert property (o_wake_irq_req
        |-> o_irq_mask && o_periph_freeze) else $error("mask");
    a_return_clears: assert property (o_wake_irq_req
        && i_return_from_interrupt |=> !o_wake_irq_req) else $error("return");
    a_unfreeze_cause: assert property ($fell(o_periph_freeze)
        |-> $past(i_usb_clock_gate) && !o_irq_mask) else $error("freeze");
    a_suspend_idle: assert property ($rose(o_usb_suspend)
        |-> idle_r >= USB_IDLE_CYC) else $error("suspend");
endmodule
bind power_down_wakeup_sequencer power_down_wakeup_sequencer_sva
    #(.WAKE_DELAY_CYC(WAKE_DELAY_CYC), .USB_IDLE_CYC(USB_IDLE_CYC))
    chk (.*);

// [test/power_down_wakeup_sequencer_test.sv]
// Self-checking bench of the wake-up sequencer.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
    n_errors++; $display("wrong value %s exp %h got %h", nm, e, g); end end
`define WT(c) begin k = 0; while ((c) !== 1'b1 && k < 2000) begin \
    @(negedge clk); k++; end if ((c) !== 1'b1) begin n_errors++; \
    $display("wrong value wait exp 1 got %b", (c)); end end
module power_down_wakeup_sequencer_test;
    logic clk = 1'b0, rst = 1'b1, enter = 1'b0, ret = 1'b0, rx = 1'b0;
    logic stable = 1'b0, gate = 1'b0;
    logic [7:0] cfg = 8'h00;
    logic pin, act, pd, rc, xt, frz, msk, irq, susp, usb;
    logic [15:0] vec;
    int n_errors = 0, checks_done = 0, k;
    always #20 clk = ~clk;
    wake_partner p (.i_core_clk(clk), .o_pin(pin), .o_usb_act(act));
    power_down_wakeup_sequencer #(.WAKE_DELAY_CYC(20), .USB_IDLE_CYC(30))
    dut (.i_core_clk(clk), .i_reset(rst), .i_power_ctrl_extension_reg(cfg),
        .i_pd_enter(enter), .i_external_wake_pin(pin), .i_usb_activity(act),
        .i_usb_rx_enable(rx), .i_osc_stable(stable), .i_usb_clock_gate(gate),
        .i_return_from_interrupt(ret), .o_powered_down(pd), .o_rc_osc_run(rc),
        .o_xtal_osc_run(xt), .o_periph_freeze(frz), .o_irq_mask(msk),
        .o_wake_irq_req(irq), .o_wake_vector(vec), .o_usb_suspend(susp),
        .o_wake_src_usb(usb));
    task automatic do_reset();
        rst = 1'b1;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        `CHK("rc", 1'b1, rc)
        `CHK("xt", 1'b1, xt)
        `CHK("pd", 1'b0, pd)
    endtask
    task automatic go(input logic [7:0] c);
        @(negedge clk);
        cfg = c;
        enter = 1'b1;
        @(negedge clk);
        enter = 1'b0;
        @(negedge clk);
        `CHK("pd", 1'b1, pd)
        `CHK("rc", 1'b0, rc)
    endtask
    task automatic hand_back();
        ret = 1'b1;
        @(negedge clk);
        ret = 1'b0;
        @(negedge clk);
    endtask
    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        do_reset();
        go(8'h80);
        fork
            p.pin_low(260);
        join_none
        `WT(rc)
        `CHK("msk", 1'b1, msk)
        `CHK("xt", 1'b0, xt)
        `WT(xt)
        repeat (30) @(negedge clk);
        `CHK("irq", 1'b0, irq)
        stable = 1'b1;
        `WT(irq)
        `CHK("vec", 16'h007b, vec)
        `CHK("frz", 1'b1, frz)
        `CHK("usb", 1'b0, usb)
        hand_back();
        `CHK("irq", 1'b0, irq)
        `CHK("frz", 1'b1, frz)
        gate = 1'b1;
        `WT(!frz)
        `CHK("msk", 1'b0, msk)
        gate = 1'b0;
        // Wake sources that must be ignored: no enable, then a suspended
        // bus whose receiver stayed off.
        for (int i = 0; i < 2; i++)
        begin
            go(i ? 8'h90 : 8'h00);
            if (i)
            begin
                repeat (40) @(negedge clk);
                `CHK("susp", 1'b1, susp)
                p.usb_burst();
            end
            else
                p.pin_low(300);
            repeat (20) @(negedge clk);
            `CHK("pd", 1'b1, pd)
            do_reset();
        end
        rx = 1'b1;
        repeat (40) @(negedge clk);
        `CHK("susp", 1'b1, susp)
        go(8'h90);
        p.usb_burst();
        `WT(irq)
        `CHK("usb", 1'b1, usb)
        gate = 1'b1;
        hand_back();
        `CHK("frz", 1'b0, frz)
        conclude();
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_errors++;
        conclude();
    end
endmodule
